// *** rtl/pmwc_defs.vh ***
// Constants for the power-mode and wake-up controller
`ifndef PMWC_DEFS_VH
`define PMWC_DEFS_VH
`define PMWC_ADDR_W        4
// Register offsets
`define PMWC_REG_MODE      4'h0
`define PMWC_REG_DOG       4'h1
`define PMWC_REG_STATUS    4'h2
`define PMWC_REG_WAKEMASK  4'h3
`define PMWC_REG_CLKSTAT   4'h4
// Mode register fields
`define PMWC_MODE_HL       0
`define PMWC_MODE_IDLE_ON_HALT_SELECT    1
`define PMWC_MODE_FST      2
`define PMWC_MODE_CKS_LO   5
`define PMWC_MODE_CKS_HI   7
// Dog register fields
`define PMWC_DOG_EN        0
`define PMWC_DOG_LVD       1
`define PMWC_DOG_WS_LO     4
`define PMWC_DOG_WS_HI     6
`define PMWC_DOG_KEEP      7
// Status register fields
`define PMWC_ST_PDF        0
`define PMWC_ST_TO         1
// Reset values
`define PMWC_MODE_RST      8'h01
`define PMWC_DOG_RST       8'h70
`define PMWC_WAKEMASK_RST  8'h00
// Timing counts in oscillator ticks; the watchdog base is a power-of-two exponent
`define PMWC_HOSC_SETTLE   16'd1024
`define PMWC_LOSC_SETTLE   16'd1024
`define PMWC_WS_BASE       5'd8
`endif

// *** rtl/pmwc_edge_sync.v ***
// Two-flop synchroniser with falling-edge detect for wake pins
`timescale 1ns/1ps
module pmwc_edge_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_pin,
  output wire [WIDTH-1:0] o_fall
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // Idle level of the pins is high, so reset to ones to avoid false edges
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_q <= {WIDTH{1'b1}};
      s2_q <= {WIDTH{1'b1}};
      s3_q <= {WIDTH{1'b1}};
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign o_fall = s3_q & ~s2_q;
endmodule // pmwc_edge_sync

// *** rtl/pmwc_dog_timer.v ***
// Watchdog counter with selectable power-of-two timeout
`timescale 1ns/1ps
`include "pmwc_defs.vh"
module pmwc_dog_timer #(
  parameter CNT_W = 15
) (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_tick,
  input  wire       i_clear,
  input  wire       i_run,
  input  wire [2:0] i_period_sel,
  output reg        o_expire
);
  reg [CNT_W-1:0] cnt_q;
  wire [4:0]      shift = `PMWC_WS_BASE + {2'b00, i_period_sel};
  wire [CNT_W:0]  limit = {{CNT_W{1'b0}}, 1'b1} << shift;
  wire [CNT_W:0]  last  = limit - {{CNT_W{1'b0}}, 1'b1};

  // Timeout is 2^(8+sel) source ticks
  always @(posedge i_clk)
  begin
    if (i_reset || i_clear)
    begin
      cnt_q    <= {CNT_W{1'b0}};
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      if (i_run && i_tick)
      begin
        if ({1'b0, cnt_q} == last)
        begin
          cnt_q    <= {CNT_W{1'b0}};
          o_expire <= 1'b1;
        end
        else
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // pmwc_dog_timer

// *** rtl/pmwc_top.v ***
// Power-mode, wake-up and watchdog controller top level
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pmwc_defs.vh"
module pmwc_top #(
  parameter PORT_W      = 8,
  parameter IRQ_W       = 4,
  parameter DOG_ON_SYS  = 1'b0,
  parameter AUX_IS_XTAL = 1'b1,
  parameter HOSC_XTAL   = 1'b1
) (
  input  wire                    i_clk,
  input  wire                    i_reset,
  input  wire [`PMWC_ADDR_W-1:0] i_addr,
  input  wire [7:0]              i_wdata,
  input  wire                    i_wr,
  input  wire                    i_rd,
  output reg  [7:0]              o_rdata,
  input  wire                    i_halt,
  input  wire                    i_dog_clear,
  input  wire                    i_aux_tick,
  input  wire                    i_hosc_tick,
  input  wire                    i_losc_tick,
  input  wire [PORT_W-1:0]       i_port_a,
  input  wire [IRQ_W-1:0]        i_irq_req,
  input  wire [IRQ_W-1:0]        i_irq_en,
  input  wire                    i_stack_full,
  input  wire                    i_ext_reset_wake,
  output wire                    o_cpu_run,
  output wire                    o_sys_clk_en,
  output wire                    o_tbase_clk_en,
  output wire                    o_aux_clk_en,
  output wire                    o_sys_on_low,
  output wire                    o_periph_on_low,
  output reg                     o_full_reset,
  output reg                     o_dog_reset,
  output reg                     o_irq_service,
  output reg                     o_resume_after_halt,
  output wire                    o_hosc_ready
);
  localparam [4:0] ST_RUN  = 5'b00001;
  localparam [4:0] ST_SL0  = 5'b00010;
  localparam [4:0] ST_SL1  = 5'b00100;
  localparam [4:0] ST_ID0  = 5'b01000;
  localparam [4:0] ST_ID1  = 5'b10000;
  localparam [2:0] SET_OFF = 3'b001;
  localparam [2:0] SET_HI  = 3'b010;
  localparam [2:0] SET_LO  = 3'b100;

  reg [7:0]        mode_q;
  reg [7:0]        dog_q;
  reg [PORT_W-1:0] wake_mask_q;
  reg              pdf_q;
  reg              to_q;
  reg [4:0]        st_q;
  reg [2:0]        set_q;
  reg [15:0]       settle_q;
  reg              hosc_rdy_q;
  reg              losc_rdy_q;
  reg              losc_pend_q;
  reg              fast_q;
  reg [IRQ_W-1:0]  irq_block_q;
  reg [1:0]        div4_q;

  wire              hl       = mode_q[`PMWC_MODE_HL];
  wire              idle_on_halt_select    = mode_q[`PMWC_MODE_IDLE_ON_HALT_SELECT];
  wire              fast_wake_enable    = mode_q[`PMWC_MODE_FST];
  wire [2:0]        cks      = mode_q[`PMWC_MODE_CKS_HI:`PMWC_MODE_CKS_LO];
  wire              dog_en   = dog_q[`PMWC_DOG_EN];
  wire              lvd_en   = dog_q[`PMWC_DOG_LVD];
  wire              keep_sys = dog_q[`PMWC_DOG_KEEP];
  wire [2:0]        ws       = dog_q[`PMWC_DOG_WS_HI:`PMWC_DOG_WS_LO];
  wire              in_run   = st_q[0];
  wire [PORT_W-1:0] port_fall;
  wire              dog_expire;

  // Decode of a register address, shared by write and read paths
  function is_reg;
    input [`PMWC_ADDR_W-1:0] a;
    input [`PMWC_ADDR_W-1:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // High-speed source wanted when HL=1 or a divided-fast setting
  wire want_high = hl | (cks[2] | cks[1]);
  wire sys_slow  = ~want_high | fast_q;

  pmwc_edge_sync #(
    .WIDTH (PORT_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_pin   (i_port_a),
    .o_fall  (port_fall)
  );

  // Dog source: aux tick or system clock divided by 4
  wire sys_running = in_run | st_q[4];
  wire div4_tick   = sys_running & (div4_q == 2'b11);
  wire dog_tick    = DOG_ON_SYS ? div4_tick : i_aux_tick;
  // Dog runs only where its source clock survives the mode
  wire dog_run = dog_en & (in_run | st_q[4] |
                 ((st_q[2] | st_q[3]) & ~DOG_ON_SYS));
  wire halt_go = in_run & i_halt & hosc_rdy_q;

  always @(posedge i_clk)
  begin
    if (i_reset)
      div4_q <= 2'b00;
    else if (sys_running)
      div4_q <= div4_q + 2'b01;
  end

  pmwc_dog_timer #(
    .CNT_W (15)
  ) u_dog (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_tick       (dog_tick),
    .i_clear      (i_dog_clear | halt_go),
    .i_run        (dog_run),
    .i_period_sel (ws),
    .o_expire     (dog_expire)
  );

  // Wake conditions
  wire [IRQ_W-1:0] irq_new  = i_irq_req & ~irq_block_q;
  wire             irq_wake = |irq_new;
  wire             pa_wake  = |(port_fall & wake_mask_q);
  wire             low_pwr  = ~in_run;
  wire             wake = low_pwr & (i_ext_reset_wake | pa_wake |
                          irq_wake | dog_expire);
  wire             irq_take = |(irq_new & i_irq_en) & ~i_stack_full;

  // Mode state machine; target state picked from mode and dog bits at HALT, FST read at wake
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q                <= ST_RUN;
      irq_block_q         <= {IRQ_W{1'b0}};
      o_full_reset        <= 1'b0;
      o_dog_reset         <= 1'b0;
      o_irq_service       <= 1'b0;
      o_resume_after_halt <= 1'b0;
      fast_q              <= 1'b0;
    end
    else
    begin
      o_full_reset        <= 1'b0;
      o_dog_reset         <= 1'b0;
      o_irq_service       <= 1'b0;
      o_resume_after_halt <= 1'b0;
      if (hosc_rdy_q)
        fast_q <= 1'b0;
      irq_block_q <= irq_block_q & i_irq_req;
      case (st_q)
        ST_RUN:
        begin
          if (halt_go)
          begin
            irq_block_q <= i_irq_req;
            if (!idle_on_halt_select)
            begin
              if (!dog_en && !lvd_en)
                st_q <= ST_SL0;
              else
                st_q <= ST_SL1;
            end
            else if (!keep_sys)
              st_q <= ST_ID0;
            else
              st_q <= ST_ID1;
          end
          else if (dog_expire)
            o_dog_reset <= 1'b1;
        end
        default:
        begin
          if (wake)
          begin
            st_q <= ST_RUN;
            fast_q <= (st_q[2] | st_q[3]) & HOSC_XTAL & fast_wake_enable;
            if (i_ext_reset_wake)
              o_full_reset <= 1'b1;
            else if (dog_expire)
              o_dog_reset <= 1'b1;
            else if (irq_wake && irq_take)
              o_irq_service <= 1'b1;
            else
              o_resume_after_halt <= 1'b1;
          end
        end
      endcase
    end
  end

  // Shared settle counter: high oscillator first, then the low crystal
  wire hosc_stopped = st_q[1] | st_q[2] | st_q[3] | ~want_high;
  wire losc_stopped = st_q[1];
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      set_q       <= SET_HI;
      settle_q    <= 16'd0;
      hosc_rdy_q  <= 1'b0;
      losc_rdy_q  <= 1'b0;
      losc_pend_q <= 1'b1;
    end
    else
    begin
      if (losc_stopped)
      begin
        losc_rdy_q  <= 1'b0;
        losc_pend_q <= AUX_IS_XTAL;
      end
      if (hosc_stopped && !(in_run && fast_q))
      begin
        hosc_rdy_q <= 1'b0;
        set_q      <= SET_OFF;
        settle_q   <= 16'd0;
      end
      else
      begin
        case (set_q)
          SET_OFF:
          begin
            if (!hosc_rdy_q)
              set_q <= SET_HI;
            else if (losc_pend_q && !losc_stopped)
              set_q <= SET_LO;
          end
          SET_HI:
          begin
            if (i_hosc_tick)
            begin
              if (settle_q == `PMWC_HOSC_SETTLE - 16'd1)
              begin
                hosc_rdy_q <= 1'b1;
                settle_q   <= 16'd0;
                set_q      <= (losc_pend_q && !losc_stopped) ?
                              SET_LO : SET_OFF;
              end
              else
                settle_q <= settle_q + 16'd1;
            end
          end
          SET_LO:
          begin
            if (i_losc_tick)
            begin
              if (settle_q == `PMWC_LOSC_SETTLE - 16'd1)
              begin
                losc_rdy_q  <= 1'b1;
                losc_pend_q <= 1'b0;
                settle_q    <= 16'd0;
                set_q       <= SET_OFF;
              end
              else
                settle_q <= settle_q + 16'd1;
            end
          end
          default:
            set_q <= SET_OFF;
        endcase
      end
    end
  end

  // Register writes; the status flags take no software writes, only hardware updates
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mode_q      <= `PMWC_MODE_RST;
      dog_q       <= `PMWC_DOG_RST;
      wake_mask_q <= `PMWC_WAKEMASK_RST;
      pdf_q       <= 1'b0;
      to_q        <= 1'b0;
    end
    else
    begin
      if (i_wr)
      begin
        if (is_reg(i_addr, `PMWC_REG_MODE))
          mode_q <= i_wdata;
        else if (is_reg(i_addr, `PMWC_REG_DOG))
          dog_q <= i_wdata;
        else if (is_reg(i_addr, `PMWC_REG_WAKEMASK))
          wake_mask_q <= i_wdata[PORT_W-1:0];
      end
      // A timeout landing in the HALT cycle still leaves its mark
      if (halt_go)
        pdf_q <= 1'b1;
      else if (i_dog_clear)
        pdf_q <= 1'b0;
      if (dog_expire)
        to_q <= 1'b1;
      else if (halt_go || i_dog_clear)
        to_q <= 1'b0;
    end
  end

  // Register reads, data one cycle after the strobe
  always @(posedge i_clk)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      if (is_reg(i_addr, `PMWC_REG_MODE))
        o_rdata <= {mode_q[7:4], hosc_rdy_q, mode_q[2:0]};
      else if (is_reg(i_addr, `PMWC_REG_DOG))
        o_rdata <= dog_q;
      else if (is_reg(i_addr, `PMWC_REG_STATUS))
        o_rdata <= {6'h00, to_q, pdf_q};
      else if (is_reg(i_addr, `PMWC_REG_WAKEMASK))
        o_rdata <= wake_mask_q;
      else if (is_reg(i_addr, `PMWC_REG_CLKSTAT))
        o_rdata <= {3'h0, st_q};
      else
        o_rdata <= 8'h00;
    end
    else
      o_rdata <= 8'h00;
  end

  // CPU holds until the high oscillator is ready, unless fast wake runs it or no high source is wanted
  assign o_cpu_run       = in_run &
                           (hosc_rdy_q | fast_q | ~want_high);
  assign o_sys_clk_en    = sys_running;
  assign o_tbase_clk_en  = in_run | st_q[3] | st_q[4];
  assign o_aux_clk_en    = ~st_q[1];
  assign o_sys_on_low    = sys_slow;
  assign o_periph_on_low = sys_slow;
  assign o_hosc_ready    = hosc_rdy_q;
endmodule // pmwc_top

// *** verification/pmwc_top_asserts.sv ***
// Port-level assertions for the power-mode and wake-up controller
`timescale 1ns/1ps
module pmwc_checker (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_halt,
  input wire logic       i_hosc_tick,
  input wire logic       i_ext_reset_wake,
  input wire logic       o_cpu_run,
  input wire logic       o_sys_clk_en,
  input wire logic       o_tbase_clk_en,
  input wire logic       o_aux_clk_en,
  input wire logic       o_sys_on_low,
  input wire logic       o_periph_on_low,
  input wire logic       o_full_reset,
  input wire logic       o_dog_reset,
  input wire logic       o_irq_service,
  input wire logic       o_resume_after_halt,
  input wire logic       o_hosc_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [15:0] settle_q;
  wire  [3:0]  wake_w;
  assign wake_w = {o_full_reset, o_dog_reset, o_irq_service,
                   o_resume_after_halt};
  // Only a lower bound: ticks during sleep also land in this count
  always_ff @(posedge i_clk)
  begin
    if (i_reset || o_hosc_ready)
      settle_q <= 16'h0000;
    else if (i_hosc_tick && settle_q != 16'hffff)
      settle_q <= settle_q + 16'h0001;
  end
  a_halt_stops_cpu: assert property (
    i_halt && o_cpu_run && o_hosc_ready |=> !o_cpu_run)
    else $error("core still running after halt");
  a_wake_onehot: assert property ($onehot0(wake_w))
    else $error("more than one wake outcome");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_sleep_sys_off: assert property (
    !o_tbase_clk_en |-> !o_sys_clk_en)
    else $error("system clock on with time base off");
  a_aux_off_all: assert property (
    !o_aux_clk_en |-> !o_tbase_clk_en && !o_sys_clk_en)
    else $error("clocks on while aux clock is off");
  a_ready_settle: assert property (
    $rose(o_hosc_ready) |-> settle_q >= 16'h03ff)
    else $error("fast oscillator ready too early");
  a_ext_wake: assert property (
    i_ext_reset_wake && !o_tbase_clk_en |=> o_full_reset)
    else $error("external wake gave no full reset");
  a_slow_run_low: assert property (
    o_cpu_run && !o_hosc_ready |-> o_sys_on_low)
    else $error("core runs on unsettled fast clock");
  a_periph_follow: assert property (
    o_cpu_run && !o_hosc_ready |-> o_periph_on_low)
    else $error("peripheral clock did not follow");
  a_resume_from_low: assert property (
    o_irq_service || o_resume_after_halt |->
      o_tbase_clk_en && !$past(o_cpu_run))
    else $error("resume without low-power stay");
  c_dog_wake: cover property (o_dog_reset);
  c_irq_wake: cover property (o_irq_service);
  c_resume: cover property (o_resume_after_halt);
  c_ext_wake: cover property (o_full_reset);
endmodule // pmwc_checker

bind pmwc_top pmwc_checker u_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt),
  .i_hosc_tick(i_hosc_tick), .i_ext_reset_wake(i_ext_reset_wake),
  .o_cpu_run(o_cpu_run), .o_sys_clk_en(o_sys_clk_en),
  .o_tbase_clk_en(o_tbase_clk_en), .o_aux_clk_en(o_aux_clk_en),
  .o_sys_on_low(o_sys_on_low), .o_periph_on_low(o_periph_on_low),
  .o_full_reset(o_full_reset), .o_dog_reset(o_dog_reset),
  .o_irq_service(o_irq_service),
  .o_resume_after_halt(o_resume_after_halt),
  .o_hosc_ready(o_hosc_ready));

// *** verification/pmwc_cpu_model.sv ***
// Behavioural core and oscillator ticks facing the controller
`timescale 1ns/1ps
module pmwc_cpu_model (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_cmd_halt,
  input  wire logic i_cmd_clear,
  input  wire logic i_cpu_run,
  input  wire logic i_hosc_ready,
  output logic      o_halt,
  output logic      o_dog_clear,
  output wire logic o_aux_tick,
  output wire logic o_hosc_tick,
  output wire logic o_losc_tick
);
  logic [1:0] div_q;
  always_ff @(posedge i_clk)
  begin
    div_q <= i_reset ? 2'h0 : div_q + 2'h1;
    // Software polls the ready flag before it may execute HALT
    o_halt <= !i_reset && i_cmd_halt && i_cpu_run && i_hosc_ready;
    // A stopped core executes no clear instruction
    o_dog_clear <= !i_reset && i_cmd_clear && i_cpu_run;
  end
  assign o_hosc_tick = 1'b1;
  assign o_losc_tick = div_q[0];
  assign o_aux_tick  = (div_q == 2'h3);
endmodule // pmwc_cpu_model

// *** verification/pmwc_tb_top.sv ***
// Self-checking bench for the power-mode and wake-up controller
`timescale 1ns/1ps
`include "pmwc_defs.vh"
module pmwc_tb_top;
  logic       i_clk, i_reset, i_wr, i_rd, cmd_halt, cmd_clear;
  logic       i_stack_full, i_ext_reset_wake;
  logic [3:0] i_addr, i_irq_req, i_irq_en;
  logic [7:0] i_wdata, i_port_a;
  wire  [7:0] o_rdata;
  wire        halt, dog_clr, aux_tk, hosc_tk, losc_tk, cpu_run, sys_en;
  wire        tb_en, aux_en, sys_low, per_low, rdy;
  wire        full_rst, dog_rst, irq_svc, resume;
  int         fails, n_compared, i;
  typedef struct { logic [7:0] mode, dog, st; logic [2:0] en; } pmwc_row_t;
  // Mode and dog settings, expected state and {sys, tbase, aux} enables
  pmwc_row_t rows [4] = '{'{8'h01, 8'h70, 8'h02, 3'h0},
    '{8'h01, 8'h71, 8'h04, 3'h1}, '{8'h03, 8'h70, 8'h08, 3'h3},
    '{8'h03, 8'hf0, 8'h10, 3'h7}};

  pmwc_cpu_model cpu (.i_clk(i_clk), .i_reset(i_reset),
    .i_cmd_halt(cmd_halt), .i_cmd_clear(cmd_clear), .i_cpu_run(cpu_run),
    .i_hosc_ready(rdy), .o_halt(halt), .o_dog_clear(dog_clr),
    .o_aux_tick(aux_tk), .o_hosc_tick(hosc_tk), .o_losc_tick(losc_tk));
  pmwc_top uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_halt(halt), .i_dog_clear(dog_clr), .i_aux_tick(aux_tk),
    .i_hosc_tick(hosc_tk), .i_losc_tick(losc_tk), .i_port_a(i_port_a),
    .i_irq_req(i_irq_req), .i_irq_en(i_irq_en),
    .i_stack_full(i_stack_full), .i_ext_reset_wake(i_ext_reset_wake),
    .o_cpu_run(cpu_run), .o_sys_clk_en(sys_en), .o_tbase_clk_en(tb_en),
    .o_aux_clk_en(aux_en), .o_sys_on_low(sys_low),
    .o_periph_on_low(per_low), .o_full_reset(full_rst),
    .o_dog_reset(dog_rst), .o_irq_service(irq_svc),
    .o_resume_after_halt(resume), .o_hosc_ready(rdy));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic expire();
    fails++;
    $display("MISMATCH wait expected event seen none");
    close_out();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata & m, e);
  endtask
  task automatic wait_ready();
    int k;
    for (k = 0; k < 3000 && !(cpu_run === 1'b1 && rdy === 1'b1); k++)
      @(posedge i_clk) #1;
    if (k == 3000) expire();
  endtask
  task automatic halt_cpu();
    wait_ready();
    @(posedge i_clk) cmd_halt <= 1'b1;
    @(posedge i_clk) cmd_halt <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  // Pulses last one cycle, so each cycle is sampled just after its edge
  task automatic wait_wake(input logic [3:0] e);
    int k;
    for (k = 0; k < 3000 && {full_rst, dog_rst, irq_svc, resume} == 4'h0;
         k++)
      @(posedge i_clk) #1;
    if (k == 3000) expire();
    chk("wake", {4'h0, full_rst, dog_rst, irq_svc, resume}, {4'h0, e});
  endtask

  initial
  begin
    {i_reset, i_wr, i_rd, cmd_halt, cmd_clear} = 5'h10;
    {i_stack_full, i_ext_reset_wake} = 2'h0;
    {i_addr, i_irq_req, i_irq_en} = 12'h000;
    i_wdata = 8'h00;
    i_port_a = 8'hff;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`PMWC_REG_MODE, `PMWC_MODE_RST, 8'hff);
    rd(`PMWC_REG_DOG, `PMWC_DOG_RST, 8'hff);
    rd(`PMWC_REG_STATUS, 8'h00, 8'hff);
    rd(`PMWC_REG_WAKEMASK, `PMWC_WAKEMASK_RST, 8'hff);
    rd(`PMWC_REG_CLKSTAT, 8'h01, 8'hff);
    wr(`PMWC_REG_STATUS, 8'h03);
    rd(`PMWC_REG_STATUS, 8'h00, 8'hff);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00, 8'hff);
    wr(`PMWC_REG_WAKEMASK, 8'hff);
    rd(`PMWC_REG_WAKEMASK, 8'hff, 8'hff);
    wait_ready();
    rd(`PMWC_REG_MODE, 8'h09, 8'hff);
    for (i = 0; i < 4; i++)
    begin
      wr(`PMWC_REG_MODE, rows[i].mode);
      wr(`PMWC_REG_DOG, rows[i].dog);
      halt_cpu();
      rd(`PMWC_REG_CLKSTAT, rows[i].st, 8'hff);
      chk("en", {5'h0, sys_en, tb_en, aux_en}, {5'h0, rows[i].en});
      rd(`PMWC_REG_STATUS, 8'h01, 8'hff);
      @(posedge i_clk) i_port_a <= 8'hfe;
      wait_wake(4'h1);
      @(posedge i_clk) i_port_a <= 8'hff;
      rd(`PMWC_REG_CLKSTAT, 8'h01, 8'hff);
    end
    // Shortest period so the timeout fits in a short run
    wr(`PMWC_REG_MODE, 8'h01);
    wr(`PMWC_REG_DOG, 8'h01);
    halt_cpu();
    wait_wake(4'h4);
    rd(`PMWC_REG_STATUS, 8'h03, 8'hff);
    wr(`PMWC_REG_DOG, 8'h70);
    wait_ready();
    @(posedge i_clk) cmd_clear <= 1'b1;
    @(posedge i_clk) cmd_clear <= 1'b0;
    rd(`PMWC_REG_STATUS, 8'h00, 8'h01);
    @(posedge i_clk) i_irq_en <= 4'h1;
    @(posedge i_clk) i_irq_req <= 4'h1;
    halt_cpu();
    repeat (20) @(posedge i_clk);
    rd(`PMWC_REG_CLKSTAT, 8'h02, 8'hff);
    @(posedge i_clk) i_irq_req <= 4'h0;
    repeat (4) @(posedge i_clk);
    @(posedge i_clk) i_irq_req <= 4'h1;
    wait_wake(4'h2);
    for (i = 0; i < 2; i++)
    begin
      @(posedge i_clk) i_irq_req <= 4'h0;
      i_irq_en <= {3'h0, i[0]};
      i_stack_full <= i[0];
      halt_cpu();
      @(posedge i_clk) i_irq_req <= 4'h1;
      wait_wake(4'h1);
    end
    @(posedge i_clk) i_irq_req <= 4'h0;
    halt_cpu();
    @(posedge i_clk) i_ext_reset_wake <= 1'b1;
    wait_wake(4'h8);
    @(posedge i_clk) i_ext_reset_wake <= 1'b0;
    rd(`PMWC_REG_CLKSTAT, 8'h01, 8'hff);
    // Slow mode runs the core without the fast oscillator
    wr(`PMWC_REG_MODE, 8'h00);
    repeat (2) @(posedge i_clk);
    #1 chk("slow", {4'h0, sys_low, per_low, cpu_run, rdy}, 8'h0e);
    // Divider 010 asks for the fast source; the core waits for it
    wr(`PMWC_REG_MODE, 8'h40);
    #1 chk("normal", {5'h0, sys_low, per_low, cpu_run}, 8'h00);
    wait_ready();
    rd(`PMWC_REG_MODE, 8'h48, 8'hff);
    // Fast wake from sleep with aux on: core runs slow until ready
    wr(`PMWC_REG_MODE, 8'h05);
    wr(`PMWC_REG_DOG, 8'h71);
    halt_cpu();
    @(posedge i_clk) i_port_a <= 8'hfe;
    wait_wake(4'h1);
    chk("fast", {4'h0, sys_low, per_low, cpu_run, rdy}, 8'h0e);
    @(posedge i_clk) i_port_a <= 8'hff;
    wait_ready();
    @(posedge i_clk) #1;
    chk("fast_done", {6'h0, sys_low, per_low}, 8'h00);
    // Reset in mid-run returns the mode, dog, status and clock-state registers to their reset values
    @(posedge i_clk) i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`PMWC_REG_MODE, `PMWC_MODE_RST, 8'hff);
    rd(`PMWC_REG_DOG, `PMWC_DOG_RST, 8'hff);
    rd(`PMWC_REG_STATUS, 8'h00, 8'hff);
    rd(`PMWC_REG_CLKSTAT, 8'h01, 8'hff);
    close_out();
  end
endmodule // pmwc_tb_top
